// *** inc/ocrs_pkg.sv ***
// shared constants and types for the output clock rate select block
package ocrs_pkg;

    // register offsets
    localparam logic [7:0] OCRS_SECOND_OUTPUT_RATE_SELECT_OFS      = 8'h61;
    localparam logic [7:0] OCRS_FIRST_OUTPUT_RATE_SELECT_OFS       = 8'h62;
    localparam logic [7:0] OCRS_SECONDARY_LOOP_FREQ_CONTROL_OFS    = 8'h64;
    localparam logic [7:0] OCRS_PRIMARY_LOOP_MULTIPLIER_CONTROL_OFS = 8'h65;
    localparam logic [7:0] OCRS_LOW_RATE_SOURCE_OFS                = 8'h7a;

    // reset values
    localparam logic [7:0] OCRS_REG_RESET = 8'h00;

    // field positions
    localparam int OCRS_SECOND_CODE_LSB  = 0;
    localparam int OCRS_FIRST_CODE_LSB   = 4;
    localparam int OCRS_SEC_FREQ_LSB     = 0;
    localparam int OCRS_PRI_FREQ_LSB     = 0;
    localparam int OCRS_PRI_SYNTH_LSB    = 4;
    localparam int OCRS_SEC_MULT_SRC_BIT = 6;
    localparam int OCRS_LOW_RATE_SRC_BIT = 7;

    // primary analog multiplier frequency codes
    localparam logic [2:0] OCRS_PRI_OC_DIGITAL = 3'h0;
    localparam logic [2:0] OCRS_PRI_OC_ANALOG  = 3'h1;
    localparam logic [2:0] OCRS_PRI_E1_12      = 3'h2;
    localparam logic [2:0] OCRS_PRI_E1_16      = 3'h3;
    localparam logic [2:0] OCRS_PRI_T1_24      = 3'h4;
    localparam logic [2:0] OCRS_PRI_T1_16      = 3'h5;

    // secondary digital loop frequency codes
    localparam logic [2:0] OCRS_SEC_OC_SQUELCH = 3'h0;
    localparam logic [2:0] OCRS_SEC_OC_NORMAL  = 3'h1;
    localparam logic [2:0] OCRS_SEC_E1_12      = 3'h2;
    localparam logic [2:0] OCRS_SEC_E1_16      = 3'h3;
    localparam logic [2:0] OCRS_SEC_T1_24      = 3'h4;
    localparam logic [2:0] OCRS_SEC_T1_16      = 3'h5;
    localparam logic [2:0] OCRS_SEC_E3         = 3'h6;
    localparam logic [2:0] OCRS_SEC_DS3        = 3'h7;

    // primary loop synthesis codes fed to the secondary multiplier
    localparam logic [1:0] OCRS_SYN_E1_12 = 2'h0;
    localparam logic [1:0] OCRS_SYN_E1_16 = 2'h1;
    localparam logic [1:0] OCRS_SYN_T1_24 = 2'h2;
    localparam logic [1:0] OCRS_SYN_T1_16 = 2'h3;

    // output rate selector codes
    localparam logic [3:0] OCRS_SEL_OFF   = 4'h0;
    localparam logic [3:0] OCRS_SEL_2K    = 4'h1;
    localparam logic [3:0] OCRS_SEL_8K    = 4'h2;
    localparam logic [3:0] OCRS_SEL_X3    = 4'h3;
    localparam logic [3:0] OCRS_SEL_SYN_A = 4'h4;
    localparam logic [3:0] OCRS_SEL_X5    = 4'h5;
    localparam logic [3:0] OCRS_SEL_P16   = 4'h6;
    localparam logic [3:0] OCRS_SEL_P12   = 4'h7;
    localparam logic [3:0] OCRS_SEL_P8    = 4'h8;
    localparam logic [3:0] OCRS_SEL_P6    = 4'h9;
    localparam logic [3:0] OCRS_SEL_P4    = 4'ha;
    localparam logic [3:0] OCRS_SEL_S64   = 4'hb;
    localparam logic [3:0] OCRS_SEL_S48   = 4'hc;
    localparam logic [3:0] OCRS_SEL_S16   = 4'hd;
    localparam logic [3:0] OCRS_SEL_S8    = 4'he;
    localparam logic [3:0] OCRS_SEL_S4    = 4'hf;

    // divide ratios, counted in source edges per output edge
    localparam logic [5:0] OCRS_DIV_1  = 6'h00;
    localparam logic [5:0] OCRS_DIV_2  = 6'h01;
    localparam logic [5:0] OCRS_DIV_4  = 6'h03;
    localparam logic [5:0] OCRS_DIV_6  = 6'h05;
    localparam logic [5:0] OCRS_DIV_8  = 6'h07;
    localparam logic [5:0] OCRS_DIV_12 = 6'h0b;
    localparam logic [5:0] OCRS_DIV_16 = 6'h0f;
    localparam logic [5:0] OCRS_DIV_48 = 6'h2f;
    localparam logic [5:0] OCRS_DIV_64 = 6'h3f;

    // rate family of an analog multiplier, one-hot
    typedef enum logic [6:0] {
        OCRS_FAM_OC    = 7'h01,
        OCRS_FAM_E3    = 7'h02,
        OCRS_FAM_DS3   = 7'h04,
        OCRS_FAM_T1_24 = 7'h08,
        OCRS_FAM_E1_16 = 7'h10,
        OCRS_FAM_T1_16 = 7'h20,
        OCRS_FAM_E1_12 = 7'h40
    } ocrs_fam_e;

endpackage

// *** src/ocrs_out_sel.sv ***
// one clock output: source selection, edge divider and off hold
module ocrs_out_sel
    import ocrs_pkg::*;
#(
    parameter bit FIRST_PORT = 1'b0
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // selection
    input  wire logic [3:0] code,
    input  wire logic       block_div6,
    // source edge ticks
    input  wire logic       pri_tick,
    input  wire logic       sec_tick,
    input  wire logic       syn_a_tick,
    input  wire logic       syn_b_tick,
    input  wire logic       low_2k_tick,
    input  wire logic       low_8k_tick,
    // clock out
    output logic            clk_out
);

    logic       src_tick;
    logic [5:0] div_end;
    logic       div_bad;
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic [3:0] code_q;
    logic       out_d;
    logic       hit;

    // source and ratio decode
    always_comb begin
        src_tick = 1'b0;
        div_end  = OCRS_DIV_1;
        div_bad  = 1'b0;
        case (code)
            OCRS_SEL_OFF:   src_tick = 1'b0;
            OCRS_SEL_2K:    src_tick = low_2k_tick;
            OCRS_SEL_8K:    src_tick = low_8k_tick;
            OCRS_SEL_X3: begin
                if (FIRST_PORT) begin
                    src_tick = pri_tick;
                    div_end  = OCRS_DIV_2;
                end else begin
                    src_tick = syn_b_tick;
                end
            end
            OCRS_SEL_SYN_A: src_tick = syn_a_tick;
            OCRS_SEL_X5: begin
                src_tick = pri_tick;
                div_end  = FIRST_PORT ? OCRS_DIV_1 : OCRS_DIV_48;
            end
            OCRS_SEL_P16: begin
                src_tick = pri_tick;
                div_end  = OCRS_DIV_16;
            end
            OCRS_SEL_P12: begin
                src_tick = pri_tick;
                div_end  = OCRS_DIV_12;
                div_bad  = block_div6;
            end
            OCRS_SEL_P8: begin
                src_tick = pri_tick;
                div_end  = OCRS_DIV_8;
            end
            OCRS_SEL_P6: begin
                src_tick = pri_tick;
                div_end  = OCRS_DIV_6;
                div_bad  = block_div6;
            end
            OCRS_SEL_P4: begin
                src_tick = pri_tick;
                div_end  = OCRS_DIV_4;
            end
            OCRS_SEL_S64: begin
                src_tick = sec_tick;
                div_end  = OCRS_DIV_64;
            end
            OCRS_SEL_S48: begin
                src_tick = sec_tick;
                div_end  = OCRS_DIV_48;
            end
            OCRS_SEL_S16: begin
                src_tick = sec_tick;
                div_end  = OCRS_DIV_16;
            end
            OCRS_SEL_S8: begin
                src_tick = sec_tick;
                div_end  = OCRS_DIV_8;
            end
            OCRS_SEL_S4: begin
                src_tick = sec_tick;
                div_end  = OCRS_DIV_4;
            end
            default:        src_tick = 1'b0;
        endcase
    end

    assign hit   = src_tick && !div_bad && (cnt_q == div_end);
    assign cnt_d = (!src_tick || div_bad) ? cnt_q : (hit ? 6'h00 : cnt_q + 6'h01);
    // off or an unavailable ratio holds the pin low
    assign out_d = (code == OCRS_SEL_OFF || div_bad) ? 1'b0 : (clk_out ^ hit);

    // a code change restarts the divider so the new rate starts from a clean phase
    always_ff @(posedge clock) begin
        if (rst || code != code_q) begin
            cnt_q   <= 6'h00;
            clk_out <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            clk_out <= out_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            code_q <= OCRS_SEL_OFF;
        end else begin
            code_q <= code;
        end
    end

endmodule

// *** src/ocrs_top.sv ***
// frequency selection registers and output rate selection for two clock outputs
module ocrs_top
    import ocrs_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    // source edge ticks, one pulse per source clock edge
    input  wire logic       pri_mult_tick,
    input  wire logic       sec_mult_tick,
    input  wire logic       syn_a_tick,
    input  wire logic       syn_b_tick,
    input  wire logic       pri_loop_2k_tick,
    input  wire logic       pri_loop_8k_tick,
    input  wire logic       sec_loop_2k_tick,
    input  wire logic       sec_loop_8k_tick,
    // multiplier configuration outputs
    output logic [6:0]      pri_mult_family,
    output logic            pri_mult_analog_fb,
    output logic            pri_mult_code_bad,
    output logic [6:0]      sec_mult_family,
    output logic            sec_mult_from_pri,
    output logic            sec_loop_squelch,
    output logic            synth_mismatch,
    // clock outputs
    output logic            first_clock_output,
    output logic            second_clock_output
);

    logic [7:0] second_output_rate_select_q;
    logic [7:0] first_output_rate_select_q;
    logic [7:0] secondary_loop_freq_control_q;
    logic [7:0] primary_loop_multiplier_control_q;
    logic [7:0] low_rate_source_q;

    wire hit_61 = reg_addr == OCRS_SECOND_OUTPUT_RATE_SELECT_OFS;
    wire hit_62 = reg_addr == OCRS_FIRST_OUTPUT_RATE_SELECT_OFS;
    wire hit_64 = reg_addr == OCRS_SECONDARY_LOOP_FREQ_CONTROL_OFS;
    wire hit_65 = reg_addr == OCRS_PRIMARY_LOOP_MULTIPLIER_CONTROL_OFS;
    wire hit_7a = reg_addr == OCRS_LOW_RATE_SOURCE_OFS;

    // unmapped addresses read as zero
    wire [7:0] rdata_d = hit_61 ? second_output_rate_select_q :
                         hit_62 ? first_output_rate_select_q :
                         hit_64 ? secondary_loop_freq_control_q :
                         hit_65 ? primary_loop_multiplier_control_q :
                         hit_7a ? low_rate_source_q : 8'h00;

    always_ff @(posedge clock) begin
        if (rst) begin
            second_output_rate_select_q       <= OCRS_REG_RESET;
            first_output_rate_select_q        <= OCRS_REG_RESET;
            secondary_loop_freq_control_q     <= OCRS_REG_RESET;
            primary_loop_multiplier_control_q <= OCRS_REG_RESET;
            low_rate_source_q                 <= OCRS_REG_RESET;
            reg_rdata                         <= 8'h00;
        end else begin
            if (reg_wr && hit_61) second_output_rate_select_q <= reg_wdata;
            if (reg_wr && hit_62) first_output_rate_select_q <= reg_wdata;
            if (reg_wr && hit_64) secondary_loop_freq_control_q <= reg_wdata;
            if (reg_wr && hit_65) primary_loop_multiplier_control_q <= reg_wdata;
            if (reg_wr && hit_7a) low_rate_source_q <= reg_wdata;
            reg_rdata <= rdata_d;
        end
    end

    // field extraction
    wire [2:0] pri_code  = primary_loop_multiplier_control_q[OCRS_PRI_FREQ_LSB +: 3];
    wire [1:0] syn_code  = primary_loop_multiplier_control_q[OCRS_PRI_SYNTH_LSB +: 2];
    wire       from_pri  = primary_loop_multiplier_control_q[OCRS_SEC_MULT_SRC_BIT];
    wire [2:0] sec_code  = secondary_loop_freq_control_q[OCRS_SEC_FREQ_LSB +: 3];
    wire [3:0] sel_two   = second_output_rate_select_q[OCRS_SECOND_CODE_LSB +: 4];
    wire [3:0] sel_one   = first_output_rate_select_q[OCRS_FIRST_CODE_LSB +: 4];
    wire       low_sec   = low_rate_source_q[OCRS_LOW_RATE_SRC_BIT];

    ocrs_fam_e pri_fam;
    ocrs_fam_e sec_fam;
    logic      pri_bad;

    // primary multiplier rate; unused codes keep the nominal rate and raise a flag
    always_comb begin
        pri_bad = 1'b0;
        case (pri_code)
            OCRS_PRI_OC_DIGITAL: pri_fam = OCRS_FAM_OC;
            OCRS_PRI_OC_ANALOG:  pri_fam = OCRS_FAM_OC;
            OCRS_PRI_E1_12:      pri_fam = OCRS_FAM_E1_12;
            OCRS_PRI_E1_16:      pri_fam = OCRS_FAM_E1_16;
            OCRS_PRI_T1_24:      pri_fam = OCRS_FAM_T1_24;
            OCRS_PRI_T1_16:      pri_fam = OCRS_FAM_T1_16;
            default: begin
                pri_fam = OCRS_FAM_OC;
                pri_bad = 1'b1;
            end
        endcase
    end

    // secondary multiplier rate; loop field ignored when fed from the primary loop
    always_comb begin
        if (from_pri) begin
            case (syn_code)
                OCRS_SYN_E1_12: sec_fam = OCRS_FAM_E1_12;
                OCRS_SYN_E1_16: sec_fam = OCRS_FAM_E1_16;
                OCRS_SYN_T1_24: sec_fam = OCRS_FAM_T1_24;
                OCRS_SYN_T1_16: sec_fam = OCRS_FAM_T1_16;
                default:        sec_fam = OCRS_FAM_E1_12;
            endcase
        end else begin
            case (sec_code)
                OCRS_SEC_OC_SQUELCH: sec_fam = OCRS_FAM_OC;
                OCRS_SEC_OC_NORMAL:  sec_fam = OCRS_FAM_OC;
                OCRS_SEC_E1_12:      sec_fam = OCRS_FAM_E1_12;
                OCRS_SEC_E1_16:      sec_fam = OCRS_FAM_E1_16;
                OCRS_SEC_T1_24:      sec_fam = OCRS_FAM_T1_24;
                OCRS_SEC_T1_16:      sec_fam = OCRS_FAM_T1_16;
                OCRS_SEC_E3:         sec_fam = OCRS_FAM_E3;
                OCRS_SEC_DS3:        sec_fam = OCRS_FAM_DS3;
                default:             sec_fam = OCRS_FAM_OC;
            endcase
        end
    end

    // squelch only applies while the secondary loop drives the multiplier
    wire squelch_d = !from_pri && (sec_code == OCRS_SEC_OC_SQUELCH);
    // unused codes are not a synthesis setting, so they never count as a clash
    wire pri_synth = !pri_bad && pri_code != OCRS_PRI_OC_DIGITAL &&
                     pri_code != OCRS_PRI_OC_ANALOG;
    // software owns this; the flag only reports a broken pairing
    wire mismatch_d = pri_synth && from_pri && (pri_fam != sec_fam);
    // the E3/DS3 families cannot divide by six or twelve
    wire pri_no_div6 = (pri_fam == OCRS_FAM_E3) || (pri_fam == OCRS_FAM_DS3);

    always_ff @(posedge clock) begin
        if (rst) begin
            pri_mult_family    <= OCRS_FAM_OC;
            pri_mult_analog_fb <= 1'b0;
            pri_mult_code_bad  <= 1'b0;
            sec_mult_family    <= OCRS_FAM_OC;
            sec_mult_from_pri  <= 1'b0;
            sec_loop_squelch   <= 1'b1;
            synth_mismatch     <= 1'b0;
        end else begin
            pri_mult_family    <= pri_fam;
            pri_mult_analog_fb <= pri_code == OCRS_PRI_OC_ANALOG;
            pri_mult_code_bad  <= pri_bad;
            sec_mult_family    <= sec_fam;
            sec_mult_from_pri  <= from_pri;
            sec_loop_squelch   <= squelch_d;
            synth_mismatch     <= mismatch_d;
        end
    end

    // low-rate ticks come from one loop for both outputs
    wire low_2k = low_sec ? sec_loop_2k_tick : pri_loop_2k_tick;
    wire low_8k = low_sec ? sec_loop_8k_tick : pri_loop_8k_tick;

    ocrs_out_sel #(
        .FIRST_PORT (1'b1)
    ) u_first (
        .clock       (clock),
        .rst         (rst),
        .code        (sel_one),
        .block_div6  (pri_no_div6),
        .pri_tick    (pri_mult_tick),
        .sec_tick    (sec_mult_tick),
        .syn_a_tick  (syn_a_tick),
        .syn_b_tick  (syn_b_tick),
        .low_2k_tick (low_2k),
        .low_8k_tick (low_8k),
        .clk_out     (first_clock_output)
    );

    ocrs_out_sel #(
        .FIRST_PORT (1'b0)
    ) u_second (
        .clock       (clock),
        .rst         (rst),
        .code        (sel_two),
        .block_div6  (pri_no_div6),
        .pri_tick    (pri_mult_tick),
        .sec_tick    (sec_mult_tick),
        .syn_a_tick  (syn_a_tick),
        .syn_b_tick  (syn_b_tick),
        .low_2k_tick (low_2k),
        .low_8k_tick (low_8k),
        .clk_out     (second_clock_output)
    );

endmodule

// *** bench/ocrs_top_asserts.sv ***
// concurrent checks on the ports of the output clock rate select block
module ocrs_top_asserts
    import ocrs_pkg::*;
(
    // clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // source ticks
    input wire logic       pri_mult_tick,
    input wire logic       syn_b_tick,
    input wire logic       pri_loop_2k_tick,
    input wire logic       sec_loop_2k_tick,
    // status and clock outputs
    input wire logic [6:0] pri_mult_family,
    input wire logic       pri_mult_analog_fb,
    input wire logic       pri_mult_code_bad,
    input wire logic [6:0] sec_mult_family,
    input wire logic       sec_mult_from_pri,
    input wire logic       sec_loop_squelch,
    input wire logic       synth_mismatch,
    input wire logic       first_clock_output,
    input wire logic       second_clock_output
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // shadow copies built from the write strobes, so no internal probe is needed
    logic [7:0] r61_q, r62_q, r64_q, r65_q, r7a_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            {r61_q, r62_q, r64_q, r65_q, r7a_q} <= 40'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                OCRS_SECOND_OUTPUT_RATE_SELECT_OFS:       r61_q <= reg_wdata;
                OCRS_FIRST_OUTPUT_RATE_SELECT_OFS:        r62_q <= reg_wdata;
                OCRS_SECONDARY_LOOP_FREQ_CONTROL_OFS:     r64_q <= reg_wdata;
                OCRS_PRIMARY_LOOP_MULTIPLIER_CONTROL_OFS: r65_q <= reg_wdata;
                OCRS_LOW_RATE_SOURCE_OFS:                 r7a_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    function automatic logic is_map(input logic [7:0] a);
        return a inside {8'h61, 8'h62, 8'h64, 8'h65, 8'h7a};
    endfunction

    // sec picks the secondary loop table, where 110 and 111 name e3 and ds3
    function automatic logic [6:0] fam(input logic [2:0] c, input logic sec);
        case (c)
            3'h2: return 7'h40;
            3'h3: return 7'h10;
            3'h4: return 7'h08;
            3'h5: return 7'h20;
            3'h6: return sec ? 7'h02 : 7'h01;
            3'h7: return sec ? 7'h04 : 7'h01;
            default: return 7'h01;
        endcase
    endfunction

    wire [6:0] pri_f = fam(r65_q[2:0], 1'b0);
    wire [6:0] sec_f = r65_q[6] ? fam({1'b0, r65_q[5:4]} + 3'h2, 1'b0) : fam(r64_q[2:0], 1'b1);
    wire       lo_tk = r7a_q[7] ? sec_loop_2k_tick : pri_loop_2k_tick;

    chk_rdata_unmapped: assert property (!is_map($past(reg_addr)) |-> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero");
    chk_rdata_readback: assert property (reg_wr && is_map(reg_addr) ##1 !reg_wr && $stable(reg_addr)
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("register readback differs");
    chk_pri_family: assert property ($stable(r65_q)[*3] |-> pri_mult_family == pri_f &&
        pri_mult_analog_fb == (r65_q[2:0] == 3'h1) && pri_mult_code_bad == (r65_q[2:1] == 2'h3))
        else $error("primary multiplier flags wrong");
    chk_sec_source: assert property (($stable(r65_q) && $stable(r64_q))[*3] |->
        sec_mult_family == sec_f && sec_mult_from_pri == r65_q[6] &&
        sec_loop_squelch == (!r65_q[6] && r64_q[2:0] == 3'h0)) else $error("secondary flags wrong");
    chk_synth_mismatch: assert property ($stable(r65_q)[*3] |-> synth_mismatch ==
        (r65_q[6] && r65_q[2:0] inside {[3'h2:3'h5]} && pri_f != sec_f))
        else $error("mismatch flag wrong");
    chk_first_off: assert property ((r62_q[7:4] == OCRS_SEL_OFF)[*3] |-> !first_clock_output)
        else $error("first output not held low when off");
    chk_second_off: assert property ((r61_q[3:0] == OCRS_SEL_OFF)[*3] |-> !second_clock_output)
        else $error("second output not held low when off");
    chk_synth_b_toggle: assert property ((r61_q[3:0] == OCRS_SEL_X3)[*3] |=>
        (second_clock_output != $past(second_clock_output)) == $past(syn_b_tick))
        else $error("second output does not follow synth b ticks");
    chk_first_undivided: assert property ((r62_q[7:4] == OCRS_SEL_X5)[*3] |=>
        (first_clock_output != $past(first_clock_output)) == $past(pri_mult_tick))
        else $error("first output does not follow multiplier ticks");
    chk_low_rate_src: assert property ((r62_q[7:4] == OCRS_SEL_2K && $stable(r7a_q))[*3] |=>
        (first_clock_output != $past(first_clock_output)) == $past(lo_tk))
        else $error("first output 2k source wrong");

    cov_mismatch: cover property (r65_q[6] && synth_mismatch);
    cov_first_rise: cover property ($rose(first_clock_output));
    cov_second_rise: cover property ($rose(second_clock_output));
endmodule

bind ocrs_top ocrs_top_asserts u_asserts (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pri_mult_tick(pri_mult_tick), .syn_b_tick(syn_b_tick),
    .pri_loop_2k_tick(pri_loop_2k_tick), .sec_loop_2k_tick(sec_loop_2k_tick),
    .pri_mult_family(pri_mult_family), .pri_mult_analog_fb(pri_mult_analog_fb),
    .pri_mult_code_bad(pri_mult_code_bad), .sec_mult_family(sec_mult_family),
    .sec_mult_from_pri(sec_mult_from_pri), .sec_loop_squelch(sec_loop_squelch),
    .synth_mismatch(synth_mismatch), .first_clock_output(first_clock_output),
    .second_clock_output(second_clock_output)
);

// *** bench/ocrs_top_tb.sv ***
// self-checking bench for the output clock rate select block
module ocrs_top_tb
    import ocrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, fast = 1'b1, slow = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [6:0] pri_mult_family, sec_mult_family;
    logic       pri_mult_analog_fb, pri_mult_code_bad, sec_mult_from_pri, sec_loop_squelch;
    logic       synth_mismatch, first_clock_output, second_clock_output;
    int         failures = 0, checked = 0;
    typedef struct { int kind; logic [31:0] exp; } ocrs_note_s;
    ocrs_note_s notes[$];
    // periods in cycles, fast sources tick every cycle and slow ones every second cycle
    int fp[16] = '{0, 2, 4, 4, 2, 2, 32, 24, 16, 12, 8, 256, 192, 64, 32, 16};
    int sp[16] = '{0, 2, 4, 4, 2, 96, 32, 24, 16, 12, 8, 256, 192, 64, 32, 16};

    always #5 clock = ~clock;
    always @(negedge clock) slow <= ~slow;

    ocrs_top uut (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .pri_mult_tick(fast), .sec_mult_tick(slow), .syn_a_tick(fast),
        .syn_b_tick(slow), .pri_loop_2k_tick(fast), .pri_loop_8k_tick(slow),
        .sec_loop_2k_tick(slow), .sec_loop_8k_tick(fast), .pri_mult_family(pri_mult_family),
        .pri_mult_analog_fb(pri_mult_analog_fb), .pri_mult_code_bad(pri_mult_code_bad),
        .sec_mult_family(sec_mult_family), .sec_mult_from_pri(sec_mult_from_pri),
        .sec_loop_squelch(sec_loop_squelch), .synth_mismatch(synth_mismatch),
        .first_clock_output(first_clock_output), .second_clock_output(second_clock_output)
    );

    task automatic test_done();
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask

    // the driver stalls until the monitor has checked and dropped the note, for at most 3000 cycles
    task automatic note(input int k, input logic [31:0] e);
        int n;
        notes.push_back('{k, e});
        for (n = 0; n < 3000 && notes.size() > 0; n++)
            @(negedge clock);
    endtask

    function automatic logic [6:0] fam(input logic [2:0] c, input logic sec);
        case (c)
            3'h2: return 7'h40;
            3'h3: return 7'h10;
            3'h4: return 7'h08;
            3'h5: return 7'h20;
            3'h6: return sec ? 7'h02 : 7'h01;
            3'h7: return sec ? 7'h04 : 7'h01;
            default: return 7'h01;
        endcase
    endfunction

    function automatic logic [31:0] status(input logic [7:0] s, input logic [7:0] p);
        logic [6:0] pf, sf;
        pf = fam(p[2:0], 1'b0);
        sf = p[6] ? fam({1'b0, p[5:4]} + 3'h2, 1'b0) : fam(s[2:0], 1'b1);
        return {13'h0, pf, p[2:0] == 3'h1, p[2:1] == 2'h3, sf, p[6], !p[6] && s[2:0] == 3'h0,
                p[6] && p[2:0] inside {[3'h2:3'h5]} && pf != sf};
    endfunction

    function automatic logic out_of(input logic first);
        return first ? first_clock_output : second_clock_output;
    endfunction

    // rise to rise in cycles; 0 when the output never rises
    task automatic period(input logic first, output logic [31:0] p);
        int n;
        logic prev;
        p = 0;
        for (n = 0; n < 700; n++) begin
            prev = out_of(first);
            @(negedge clock);
            if (!prev && out_of(first)) break;
        end
        if (n == 700) return;
        for (n = 1; n < 700; n++) begin
            prev = out_of(first);
            @(negedge clock);
            if (!prev && out_of(first)) break;
        end
        p = n;
    endtask

    initial begin
        logic [31:0] seen;
        ocrs_note_s  cur;
        forever begin
            wait (notes.size() > 0);
            cur = notes[0];
            case (cur.kind)
                0: begin
                    repeat (2) @(negedge clock);
                    chk("reg_rdata", {24'h0, reg_rdata}, cur.exp);
                end
                1: begin
                    period(1'b1, seen);
                    chk("first period", seen, cur.exp);
                end
                2: begin
                    period(1'b0, seen);
                    chk("second period", seen, cur.exp);
                end
                default: begin
                    repeat (4) @(negedge clock);
                    chk("loop status", {13'h0, pri_mult_family, pri_mult_analog_fb,
                        pri_mult_code_bad, sec_mult_family, sec_mult_from_pri,
                        sec_loop_squelch, synth_mismatch}, cur.exp);
                end
            endcase
            void'(notes.pop_front());
        end
    end

    initial begin
        #900000;
        failures++;
        test_done();
    end

    initial begin
        logic [7:0] maps[5];
        logic [7:0] d, s;
        int         i;
        maps = '{OCRS_SECOND_OUTPUT_RATE_SELECT_OFS, OCRS_FIRST_OUTPUT_RATE_SELECT_OFS,
                 OCRS_SECONDARY_LOOP_FREQ_CONTROL_OFS, OCRS_PRIMARY_LOOP_MULTIPLIER_CONTROL_OFS,
                 OCRS_LOW_RATE_SOURCE_OFS};
        repeat (20) @(negedge clock);
        rst = 1'b0;
        void'($urandom(66));
        for (i = 0; i < 5; i++) begin
            @(negedge clock);
            reg_addr = maps[i];
            note(0, OCRS_REG_RESET);
        end
        for (i = 0; i < 6; i++) begin
            d = 8'($urandom);
            wr(i < 5 ? maps[i] : 8'h63, d);
            note(0, i < 5 ? d : 8'h00);
        end
        // bit 6 clear: primary code and secondary loop code walk all values
        for (i = 0; i < 8; i++) begin
            wr(OCRS_PRIMARY_LOOP_MULTIPLIER_CONTROL_OFS, 8'(i));
            wr(OCRS_SECONDARY_LOOP_FREQ_CONTROL_OFS, 8'(7 - i));
            note(3, status(8'(7 - i), 8'(i)));
        end
        // bit 6 set: secondary loop code is ignored; random primary codes both match and clash
        for (i = 0; i < 8; i++) begin
            d = {2'b01, 2'(i), 1'b0, i == 7 ? 3'h7 : 3'h2 + 3'($urandom_range(0, 3))};
            s = 8'($urandom);
            wr(OCRS_SECONDARY_LOOP_FREQ_CONTROL_OFS, s);
            wr(OCRS_PRIMARY_LOOP_MULTIPLIER_CONTROL_OFS, d);
            note(3, status(s, d));
        end
        wr(OCRS_PRIMARY_LOOP_MULTIPLIER_CONTROL_OFS, 8'h00);
        wr(OCRS_SECONDARY_LOOP_FREQ_CONTROL_OFS, 8'h01);
        wr(OCRS_LOW_RATE_SOURCE_OFS, 8'h00);
        for (i = 0; i < 16; i++) begin
            wr(OCRS_FIRST_OUTPUT_RATE_SELECT_OFS, 8'(i) << 4);
            wr(OCRS_SECOND_OUTPUT_RATE_SELECT_OFS, 8'(i));
            note(1, fp[i]);
            note(2, sp[i]);
        end
        wr(OCRS_LOW_RATE_SOURCE_OFS, 8'h80);
        wr(OCRS_FIRST_OUTPUT_RATE_SELECT_OFS, {OCRS_SEL_2K, 4'h0});
        wr(OCRS_SECOND_OUTPUT_RATE_SELECT_OFS, {4'h0, OCRS_SEL_8K});
        note(1, 4);
        note(2, 2);
        test_done();
    end
endmodule
